// File: param_access.sv
// Parameter access, security and command execution with AXI4-Lite slave
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module param_access (
  input wire logic clk,
  input wire logic reset_n,
  input wire param_access_pkg::axi_req_type axi_req,
  output param_access_pkg::axi_rsp_type axi_rsp,
  input wire logic keypad_reset_btn,
  input wire logic keypad_enter_commit,
  input wire logic undervoltage,
  input wire logic enable_terminals,
  output logic [1:0] op_mode,
  output param_access_pkg::perm_type perm,
  output logic nv_save,
  output logic load_defaults_50,
  output logic load_defaults_60
);
  import param_access_pkg::*;

  typedef struct packed {
    logic aw_ok;
    logic [ADDR_W-1:0] aw_addr;
    logic w_ok;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] mode;
    logic sw_enable;
    logic [15:0] cmd;
    logic [2:0] level;
    logic [13:0] code_pending;
    logic [13:0] code_active;
    logic unlocked;
    logic [PIN_N-1:0] sync1;
    logic [PIN_N-1:0] sync2;
    logic [PIN_N-1:0] prev;
    logic nv_save;
    logic def50;
    logic def60;
    logic [1:0] done;
    perm_type perm;
  } state_type;

  state_type st_reg;
  state_type st_next;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Access level and security state to visibility and write rights
  function automatic perm_type perms(input logic [2:0] level,
                                     input logic closed);
    perm_type p;
    p = '0;
    p.comms_allowed = 1'b1;
    unique case (level)
      LEVEL_MENU0: begin
        p.menu0_visible = 1'b1;
        p.menu0_writable = !closed;
      end
      LEVEL_ALL: begin
        p.menu0_visible = 1'b1;
        p.adv_visible = 1'b1;
        p.menu0_writable = !closed;
        p.adv_writable = !closed;
      end
      LEVEL_RO_MENU0: begin
        p.menu0_visible = 1'b1;
      end
      LEVEL_RO_ALL: begin
        p.menu0_visible = 1'b1;
        p.adv_visible = 1'b1;
      end
      LEVEL_STATUS: begin
        p.keypad_status_only = 1'b1;
      end
      default: begin
        p.keypad_status_only = 1'b1;
        p.comms_allowed = 1'b0;
      end
    endcase
    return p;
  endfunction

  logic drive_disabled;
  logic uv;
  logic sec_closed;
  logic reset_req;
  logic wr_fire;
  logic [31:0] wr_word;

  // Qualified pin levels after synchronisation
  assign uv = st_reg.sync2[PIN_UV];
  assign drive_disabled = !st_reg.sync2[PIN_EN] || !st_reg.sw_enable;
  assign sec_closed = (st_reg.code_active != CODE_NONE) && !st_reg.unlocked;
  assign wr_fire = st_reg.aw_ok && st_reg.w_ok && !st_reg.bvalid;

  // Handshake outputs
  assign axi_rsp.awready = !st_reg.aw_ok && !st_reg.bvalid;
  assign axi_rsp.wready = !st_reg.w_ok && !st_reg.bvalid;
  assign axi_rsp.arready = !st_reg.rvalid;
  assign axi_rsp.bvalid = st_reg.bvalid;
  assign axi_rsp.bresp = st_reg.bresp;
  assign axi_rsp.rvalid = st_reg.rvalid;
  assign axi_rsp.rdata = st_reg.rdata;
  assign axi_rsp.rresp = st_reg.rresp;
  assign op_mode = st_reg.mode;
  assign perm = st_reg.perm;
  assign nv_save = st_reg.nv_save;
  assign load_defaults_50 = st_reg.def50;
  assign load_defaults_60 = st_reg.def60;

  // Next-state logic
  always_comb begin
    st_next = st_reg;
    reset_req = 1'b0;
    wr_word = '0;
    st_next.nv_save = 1'b0;
    st_next.def50 = 1'b0;
    st_next.def60 = 1'b0;
    st_next.sync1 = {enable_terminals, undervoltage,
                     keypad_enter_commit, keypad_reset_btn};
    st_next.sync2 = st_reg.sync1;
    st_next.prev = st_reg.sync2;
    // Red button press requests a drive reset
    if (st_reg.sync2[PIN_BTN] && !st_reg.prev[PIN_BTN]) begin
      reset_req = 1'b1;
    end
    // Menu 0 edit committed on Enter
    if (st_reg.sync2[PIN_ENTER] && !st_reg.prev[PIN_ENTER] &&
        st_reg.perm.menu0_writable) begin
      st_next.nv_save = 1'b1;
    end
    // Write address and data taken in either order
    if (axi_req.awvalid && axi_rsp.awready) begin
      st_next.aw_ok = 1'b1;
      st_next.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      st_next.w_ok = 1'b1;
      st_next.w_data = axi_req.wdata;
      st_next.w_strb = axi_req.wstrb;
    end
    if (st_reg.bvalid && axi_req.bready) begin
      st_next.bvalid = 1'b0;
    end
    // Register write once both halves are held
    if (wr_fire) begin
      st_next.aw_ok = 1'b0;
      st_next.w_ok = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      unique case (st_reg.aw_addr)
        ADDR_MODE: begin
          wr_word = merge({27'h000_0000, st_reg.sw_enable, 2'h0,
                           st_reg.mode}, st_reg.w_data, st_reg.w_strb);
          st_next.sw_enable = wr_word[SW_ENABLE_BIT];
          if (wr_word[MODE_LSB +: 2] != st_reg.mode) begin
            if ((wr_word[MODE_LSB +: 2] == OPEN_LOOP_MODE ||
                 wr_word[MODE_LSB +: 2] == ROTOR_FLUX_VECTOR_MODE) &&
                drive_disabled && st_reg.perm.menu0_writable &&
                st_reg.perm.comms_allowed) begin
              st_next.mode = wr_word[MODE_LSB +: 2];
              st_next.nv_save = 1'b1;
            end else begin
              st_next.bresp = RESP_SLVERR;
            end
          end
        end
        ADDR_CMD: begin
          wr_word = merge({16'h0000, st_reg.cmd}, st_reg.w_data,
                          st_reg.w_strb);
          if (st_reg.perm.comms_allowed) begin
            st_next.cmd = wr_word[15:0];
          end else begin
            st_next.bresp = RESP_SLVERR;
          end
        end
        ADDR_RESET: begin
          wr_word = merge(32'h0000_0000, st_reg.w_data, st_reg.w_strb);
          if (!st_reg.perm.comms_allowed) begin
            st_next.bresp = RESP_SLVERR;
          end else if (wr_word[15:0] == RESET_REQUEST) begin
            reset_req = 1'b1;
          end
        end
        ADDR_LEVEL: begin
          wr_word = merge({29'h0000_0000, st_reg.level}, st_reg.w_data,
                          st_reg.w_strb);
          if (wr_word[2:0] <= LEVEL_NO_ACCESS) begin
            st_next.level = wr_word[2:0];
          end else begin
            st_next.bresp = RESP_SLVERR;
          end
        end
        ADDR_CODE: begin
          wr_word = merge({18'h0_0000, st_reg.code_pending},
                          st_reg.w_data, st_reg.w_strb);
          if (!st_reg.perm.comms_allowed || sec_closed ||
              wr_word[13:0] > CODE_MAX) begin
            st_next.bresp = RESP_SLVERR;
          end else begin
            st_next.code_pending = wr_word[13:0];
          end
        end
        ADDR_UNLOCK: begin
          wr_word = merge(32'h0000_0000, st_reg.w_data, st_reg.w_strb);
          if (wr_word[13:0] == st_reg.code_active) begin
            st_next.unlocked = 1'b1;
          end else begin
            st_next.bresp = RESP_SLVERR;
          end
        end
        ADDR_STATUS: begin
          st_next.bresp = RESP_OKAY;
        end
        default: begin
          st_next.bresp = RESP_DECERR;
        end
      endcase
    end
    // Drive reset: run the armed command, activate the code, relock
    if (reset_req) begin
      st_next.code_active = st_next.code_pending;
      st_next.unlocked = 1'b0;
      st_next.done = 2'h0;
      unique case (st_next.cmd)
        CMD_SAVE: begin
          if (!uv) begin
            st_next.nv_save = 1'b1;
            st_next.done = 2'h1;
          end
        end
        CMD_SAVE_UV: begin
          if (uv) begin
            st_next.nv_save = 1'b1;
            st_next.done = 2'h1;
          end
        end
        CMD_DEF50: begin
          st_next.def50 = 1'b1;
          st_next.nv_save = 1'b1;
          st_next.done = 2'h2;
        end
        CMD_DEF60: begin
          st_next.def60 = 1'b1;
          st_next.nv_save = 1'b1;
          st_next.done = 2'h3;
        end
        default: begin
          st_next.done = 2'h0;
        end
      endcase
      st_next.cmd = CMD_NONE;
    end
    // Read channel, one cycle after address taken
    if (st_reg.rvalid && axi_req.rready) begin
      st_next.rvalid = 1'b0;
    end
    if (axi_req.arvalid && axi_rsp.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      st_next.rdata = '0;
      unique case (axi_req.araddr)
        ADDR_MODE: begin
          st_next.rdata[MODE_LSB +: 2] = st_reg.mode;
          st_next.rdata[SW_ENABLE_BIT] = st_reg.sw_enable;
        end
        ADDR_CMD: st_next.rdata[15:0] = st_reg.cmd;
        ADDR_RESET: st_next.rdata = '0;
        ADDR_LEVEL: st_next.rdata[2:0] = st_reg.level;
        ADDR_CODE: st_next.rdata = '0;
        ADDR_UNLOCK: st_next.rdata = '0;
        ADDR_STATUS: begin
          st_next.rdata[ST_DISABLED] = drive_disabled;
          st_next.rdata[ST_UNDERVOLT] = uv;
          st_next.rdata[ST_CLOSED] = sec_closed;
          st_next.rdata[ST_PERM_LSB +: 6] = st_reg.perm;
          st_next.rdata[ST_DONE_LSB +: 2] = st_reg.done;
        end
        default: st_next.rresp = RESP_DECERR;
      endcase
      if (!st_reg.perm.comms_allowed && axi_req.araddr != ADDR_LEVEL &&
          axi_req.araddr != ADDR_STATUS) begin
        st_next.rdata = '0;
        st_next.rresp = RESP_SLVERR;
      end
    end
    // Level and security combine independently into rights
    st_next.perm = perms(st_next.level,
                         (st_next.code_active != CODE_NONE) &&
                         !st_next.unlocked);
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
      st_reg.mode <= OPEN_LOOP_MODE;
      st_reg.level <= LEVEL_MENU0;
      st_reg.perm.menu0_visible <= 1'b1;
      st_reg.perm.menu0_writable <= 1'b1;
      st_reg.perm.comms_allowed <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// File: param_access_pkg.sv
// Constants, field layouts and carrier types for parameter access control
// What this block does
// - Mode value 1 open loop, 2 vector
// - Any mode change triggers a full save
// - Menu 0 edit saved on Enter
// - Advanced edits saved only by save command
// - Code 1000 arms save for next reset
// - Reset from keypad button or serial 100
// - Under-voltage save needs code 1001 instead
// - Codes 1233/1244 load 50/60 Hz defaults
// - Defaults also saved, security left untouched
// - Level 0: Menu 0 only, editable when open
// - Level 1: all menus, editable when open
// - Level 2: Menu 0 only, read-only
// - Level 3: all visible, all read-only
// - Level 4: keypad held in status mode
// - Closed security forces visible parameters read-only
// - Level and security evaluated independently, all combos
// - Reset state: level 0, security open
// - Code 1..9999, active after reset, reads 0
// - Level stays changeable while code is set
package param_access_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_LEVEL = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_CODE = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h18;
  // Mode register fields
  localparam int MODE_LSB = 0;
  localparam int SW_ENABLE_BIT = 4;
  localparam logic [1:0] OPEN_LOOP_MODE = 2'h1;
  localparam logic [1:0] ROTOR_FLUX_VECTOR_MODE = 2'h2;
  // Command codes: 1000, 1001, 1233, 1244, reset value 100
  localparam logic [15:0] CMD_NONE = 16'h0000;
  localparam logic [15:0] CMD_SAVE = 16'h03E8;
  localparam logic [15:0] CMD_SAVE_UV = 16'h03E9;
  localparam logic [15:0] CMD_DEF50 = 16'h04D1;
  localparam logic [15:0] CMD_DEF60 = 16'h04DC;
  localparam logic [15:0] RESET_REQUEST = 16'h0064;
  // Access levels
  localparam logic [2:0] LEVEL_MENU0 = 3'h0;
  localparam logic [2:0] LEVEL_ALL = 3'h1;
  localparam logic [2:0] LEVEL_RO_MENU0 = 3'h2;
  localparam logic [2:0] LEVEL_RO_ALL = 3'h3;
  localparam logic [2:0] LEVEL_STATUS = 3'h4;
  localparam logic [2:0] LEVEL_NO_ACCESS = 3'h5;
  // Security code limit 9999
  localparam logic [13:0] CODE_NONE = 14'h0000;
  localparam logic [13:0] CODE_MAX = 14'h270F;
  // Status register fields
  localparam int ST_DISABLED = 0;
  localparam int ST_UNDERVOLT = 1;
  localparam int ST_CLOSED = 2;
  localparam int ST_PERM_LSB = 8;
  localparam int ST_DONE_LSB = 16;
  // Pin sync lanes
  localparam int PIN_BTN = 0;
  localparam int PIN_ENTER = 1;
  localparam int PIN_UV = 2;
  localparam int PIN_EN = 3;
  localparam int PIN_N = 4;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_type;

  typedef struct packed {
    logic menu0_visible;
    logic menu0_writable;
    logic adv_visible;
    logic adv_writable;
    logic keypad_status_only;
    logic comms_allowed;
  } perm_type;
endpackage

// File: param_access_monitor.sv
// Assertion checker for the parameter access block
`timescale 1ns/1ps
module param_access_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire param_access_pkg::axi_req_type axi_req,
  input wire param_access_pkg::axi_rsp_type axi_rsp,
  input wire logic keypad_reset_btn,
  input wire logic keypad_enter_commit,
  input wire logic undervoltage,
  input wire logic enable_terminals,
  input wire logic [1:0] op_mode,
  input wire param_access_pkg::perm_type perm,
  input wire logic nv_save,
  input wire logic load_defaults_50,
  input wire logic load_defaults_60
);
  import param_access_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Mode encoding and save on every mode change
  a_mode_legal: assert property (op_mode inside {2'h1, 2'h2})
    else $error("operating mode outside the two legal values");
  a_mode_save: assert property ($changed(op_mode) |-> ##[0:1] nv_save)
    else $error("mode changed without a save pulse");
  // Defaults loads come singly and always with a save
  a_def_save: assert property (load_defaults_50 || load_defaults_60 |-> nv_save)
    else $error("defaults loaded without a save pulse");
  a_def_single: assert property (!(load_defaults_50 && load_defaults_60))
    else $error("both default sets loaded at once");
  // Permission vector stays within the level and security table
  a_perm_legal: assert property (perm inside {6'h31, 6'h21, 6'h3D, 6'h29, 6'h03, 6'h02})
    else $error("permission combination not in the table");
  a_closed_ro: assert property (perm.adv_writable |-> perm.menu0_writable)
    else $error("advanced menus writable while menu 0 is not");
  a_status_hides: assert property (perm.keypad_status_only |-> !perm.menu0_visible && !perm.adv_visible)
    else $error("menus visible in status display mode");
  // Read answers come on time and write responses hold until taken
  a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read answer late");
  a_resp_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped before it was taken");
  c_def50: cover property (load_defaults_50);
  c_def60: cover property (load_defaults_60);
  c_closed_all: cover property (perm == 6'h29);
endmodule
bind param_access param_access_monitor i_mon (.clk(clk), .reset_n(reset_n),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .keypad_reset_btn(keypad_reset_btn),
  .keypad_enter_commit(keypad_enter_commit), .undervoltage(undervoltage),
  .enable_terminals(enable_terminals), .op_mode(op_mode), .perm(perm),
  .nv_save(nv_save), .load_defaults_50(load_defaults_50),
  .load_defaults_60(load_defaults_60));

// File: keypad_model.sv
// Keypad operator and supply pins driven into the parameter access block
`timescale 1ns/1ps
module keypad_model (
  input wire logic clk,
  output logic reset_btn,
  output logic enter_btn,
  output logic uv,
  output logic drive_enable
);
  // Idle pins; drive kept disabled before mode or defaults changes
  initial begin
    reset_btn = 1'b0;
    enter_btn = 1'b0;
    uv = 1'b0;
    drive_enable = 1'b0;
  end
  // Button held four cycles, then time for the sync stages
  task automatic press(input logic which);
    @(posedge clk);
    if (which) enter_btn <= 1'b1;
    else reset_btn <= 1'b1;
    repeat (4) @(posedge clk);
    enter_btn <= 1'b0;
    reset_btn <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // Hardware enable terminals, settled past the sync stages
  task automatic set_enable(input logic v);
    @(posedge clk);
    drive_enable <= v;
    repeat (6) @(posedge clk);
  endtask
  // Auxiliary supply state, settled past the sync stages
  task automatic set_uv(input logic v);
    @(posedge clk);
    uv <= v;
    repeat (6) @(posedge clk);
  endtask
endmodule

// File: parameter_access_security_test.sv
// Self-checking bench for the parameter access block
`timescale 1ns/1ps
module parameter_access_security_test;
  import param_access_pkg::*;
  logic clk, reset_n, btn, enter, uv, en, nv_save, d50, d60;
  axi_req_type axi_req;
  axi_rsp_type axi_rsp;
  logic [1:0] op_mode;
  perm_type perm;
  int failures = 0, n_checks = 0, cyc = 0;
  int n_save = 0, n_50 = 0, n_60 = 0, es = 2, e50 = 0, e60 = 0;
  logic [15:0] codes[6] = '{CMD_SAVE, CMD_SAVE_UV, CMD_DEF50, CMD_DEF60,
    CMD_SAVE, CMD_SAVE_UV};
  logic uvs[6] = '{0, 0, 0, 0, 1, 1};
  int saves[6] = '{1, 0, 1, 1, 0, 1};

  param_access i_dut (.clk(clk), .reset_n(reset_n), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .keypad_reset_btn(btn), .keypad_enter_commit(enter),
    .undervoltage(uv), .enable_terminals(en), .op_mode(op_mode),
    .perm(perm), .nv_save(nv_save), .load_defaults_50(d50),
    .load_defaults_60(d60));
  keypad_model i_kp (.clk(clk), .reset_btn(btn), .enter_btn(enter),
    .uv(uv), .drive_enable(en));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Pulse counters and hang limit
  always @(posedge clk) begin
    if (nv_save === 1'b1) n_save++;
    if (d50 === 1'b1) n_50++;
    if (d60 === 1'b1) n_60++;
    cyc++;
    if (cyc == 6000) begin
      failures++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Expected permissions from level and security state
  function automatic perm_type exp_perm(logic [2:0] l, logic c);
    case (l)
      LEVEL_MENU0: return {1'b1, !c, 4'h1};
      LEVEL_ALL: return {1'b1, !c, 1'b1, !c, 2'h1};
      LEVEL_RO_MENU0: return 6'h21;
      LEVEL_RO_ALL: return 6'h29;
      LEVEL_STATUS: return 6'h03;
      default: return 6'h02;
    endcase
  endfunction
  // Bus write: address and data offered together, each held until taken
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    logic aw_on, w_on, aw_ok, w_ok;
    @(posedge clk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.bready <= 1'b1;
    aw_on = 1'b1;
    w_on = 1'b1;
    while (aw_on || w_on) begin
      @(negedge clk);
      aw_ok = aw_on && (axi_rsp.awready === 1'b1);
      w_ok = w_on && (axi_rsp.wready === 1'b1);
      @(posedge clk);
      if (aw_ok) axi_req.awvalid <= 1'b0;
      if (w_ok) axi_req.wvalid <= 1'b0;
      aw_on = aw_on && !aw_ok;
      w_on = w_on && !w_ok;
    end
    do @(negedge clk); while (axi_rsp.bvalid !== 1'b1);
    chk("bresp", er, axi_rsp.bresp);
    @(posedge clk);
    axi_req.bready <= 1'b0;
  endtask
  // Bus read with expected data and response
  task automatic rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
    @(posedge clk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    do @(negedge clk); while (axi_rsp.arready !== 1'b1);
    @(posedge clk);
    axi_req.arvalid <= 1'b0;
    do @(negedge clk); while (axi_rsp.rvalid !== 1'b1);
    chk("rdata", ed, axi_rsp.rdata);
    chk("rresp", er, axi_rsp.rresp);
    @(posedge clk);
    axi_req.rready <= 1'b0;
  endtask
  // Pulse totals after the last pulse has landed
  task automatic pulses(int s, int f, int x);
    repeat (3) @(posedge clk);
    chk("saves", s, n_save);
    chk("def50", f, n_50);
    chk("def60", x, n_60);
  endtask

  // Main sequence
  initial begin
    axi_req = '0;
    reset_n = 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk("op_mode", 32'h1, op_mode);
    chk("perm", exp_perm(LEVEL_MENU0, 1'b0), perm);
    rd(8'h1C, 32'h0, RESP_DECERR);
    rd(ADDR_MODE, 32'h1, RESP_OKAY);
    wr(ADDR_MODE, 32'h2, RESP_OKAY);
    chk("op_mode", 32'h2, op_mode);
    pulses(1, 0, 0);
    wr(ADDR_MODE, 32'h3, RESP_SLVERR);
    // Drive enabled: mode change refused until disabled again
    wr(ADDR_MODE, 32'h12, RESP_OKAY);
    i_kp.set_enable(1'b1);
    wr(ADDR_MODE, 32'h11, RESP_SLVERR);
    rd(ADDR_STATUS, 32'h0000_3100, RESP_OKAY);
    rd(ADDR_MODE, 32'h12, RESP_OKAY);
    wr(ADDR_MODE, 32'h2, RESP_OKAY);
    i_kp.set_enable(1'b0);
    i_kp.press(1'b1);
    pulses(2, 0, 0);
    wr(ADDR_LEVEL, 32'h1, RESP_OKAY);
    wr(ADDR_CMD, CMD_SAVE, RESP_OKAY);
    pulses(2, 0, 0);
    // Every command code, by button and by serial request in turn
    foreach (codes[i]) begin
      i_kp.set_uv(uvs[i]);
      wr(ADDR_CMD, codes[i], RESP_OKAY);
      if (i % 2 == 1) wr(ADDR_RESET, RESET_REQUEST, RESP_OKAY);
      else i_kp.press(1'b0);
      es += saves[i];
      e50 += (i == 2);
      e60 += (i == 3);
      pulses(es, e50, e60);
      rd(ADDR_CMD, 32'h0, RESP_OKAY);
    end
    i_kp.set_uv(1'b0);
    rd(ADDR_LEVEL, 32'h1, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0001_3D01, RESP_OKAY);
    // Every access level with security open
    for (int l = 0; l < 6; l++) begin
      wr(ADDR_LEVEL, l, RESP_OKAY);
      chk("perm", exp_perm(l[2:0], 1'b0), perm);
    end
    rd(ADDR_MODE, 32'h0, RESP_SLVERR);
    wr(ADDR_CMD, CMD_SAVE, RESP_SLVERR);
    wr(ADDR_LEVEL, 32'h2, RESP_OKAY);
    wr(ADDR_MODE, 32'h1, RESP_SLVERR);
    // Security code set, armed by reset, unlocked
    wr(ADDR_LEVEL, 32'h1, RESP_OKAY);
    wr(ADDR_CODE, 32'h5, RESP_OKAY);
    rd(ADDR_CODE, 32'h0, RESP_OKAY);
    chk("perm", exp_perm(LEVEL_ALL, 1'b0), perm);
    wr(ADDR_RESET, RESET_REQUEST, RESP_OKAY);
    chk("perm", exp_perm(LEVEL_ALL, 1'b1), perm);
    wr(ADDR_MODE, 32'h1, RESP_SLVERR);
    wr(ADDR_LEVEL, 32'h0, RESP_OKAY);
    chk("perm", exp_perm(LEVEL_MENU0, 1'b1), perm);
    wr(ADDR_UNLOCK, 32'h6, RESP_SLVERR);
    wr(ADDR_UNLOCK, 32'h5, RESP_OKAY);
    chk("perm", exp_perm(LEVEL_MENU0, 1'b0), perm);
    wr(ADDR_CODE, 32'h2710, RESP_SLVERR);
    close_out();
  end
endmodule
